// >>> inc/sdim_pkg.sv
// sdim_pkg: constants and types for the supply-droop and interrupt-mask register bank
// assumes an 8-bit register address space on the control port, single clock domain
package sdim_pkg;
    // register addresses
    localparam logic [7:0] SDIM_ADDR_SUPPLY_CTRL   = 8'h2d;
    localparam logic [7:0] SDIM_ADDR_DROOP_THRESH  = 8'h2e;
    localparam logic [7:0] SDIM_ADDR_SYS_MASK      = 8'h2f;
    localparam logic [7:0] SDIM_ADDR_OH_MASK       = 8'h32;
    localparam logic [7:0] SDIM_ADDR_SYS_LATCH     = 8'h34;

    // reset values
    localparam logic [1:0] SDIM_RST_SUPPLY_CTRL    = 2'h0;
    localparam logic [7:0] SDIM_RST_DROOP_THRESH   = 8'hbf;
    localparam logic [7:0] SDIM_RST_SYS_MASK       = 8'hff;
    localparam logic [7:0] SDIM_RST_OH_MASK        = 8'h00;
    localparam logic [7:0] SDIM_RST_SYS_LATCH      = 8'h00;
    localparam logic [7:0] SDIM_READ_UNMAPPED      = 8'h00;

    // field positions in the supply control register
    localparam int SDIM_BIT_SUPPLY_SELECT = 1;
    localparam int SDIM_BIT_DROOP_ENABLE  = 0;

    // field positions in the system mask and latch registers
    localparam int SDIM_BIT_CLK_ERR       = 7;
    localparam int SDIM_BIT_PLL_LOCK      = 6;

    // field positions in the output and headset mask register
    localparam int SDIM_BIT_OUT_SHORT     = 5;
    localparam int SDIM_BIT_DRV_VGND      = 4;
    localparam int SDIM_BIT_HS_INSERT     = 3;
    localparam int SDIM_BIT_HS_REMOVE     = 2;
    localparam int SDIM_BIT_HS_HOOK       = 1;

    // supply measurement: 12-bit code, threshold compares the upper 8 bits (code x 16)
    localparam int SDIM_SAMPLE_W          = 12;
    localparam int SDIM_THRESH_SHIFT      = 4;

    // event pulses from the clock, pll, output driver and headset detect logic
    typedef struct packed {
        logic clkErr;
        logic pllLock;
        logic outShort;
        logic drvVgnd;
        logic hsInsert;
        logic hsRemove;
        logic hsHook;
    } sdim_events_t;

    // register access request from the control port
    typedef struct packed {
        logic       write;
        logic       read;
        logic [7:0] addr;
        logic [7:0] wdata;
    } sdim_req_t;
endpackage

// >>> rtl/sdim_regs.sv
// sdim_regs: supply-droop control, droop threshold and interrupt-mask register bank
// assumes the control port decoder hands over one-cycle read/write strobes on clk,
// and that event pulses and supply samples come from logic on the same clock
// What this block does
// - select bit picks battery or analog supply
// - droop shutdown enable bit, resets cleared
// - 8-bit threshold register, resets to 0xbf
// - threshold compares measurement upper eight bits
// - system mask bit 7 masks clock error
// - system mask bit 6 masks pll lock
// - bit 5 masks output short fault
// - bit 4 masks virtual ground fault
// - bit 3 masks headset insertion
// - bit 2 masks headset removal
// - bit 1 masks headset hook button
// - latched readback at 0x34, clears on read
`timescale 1ns/10ps
module sdim_regs (
    // clock and reset
    input  wire logic                      clk,
    input  wire logic                      reset,
    // register access from the control port
    input  wire sdim_pkg::sdim_req_t       regReq,
    output logic [7:0]                     regRdata,
    output logic                           regRvalid,
    // supply measurements from the converter
    input  wire logic [11:0]               vbatSample,
    input  wire logic [11:0]               avddSample,
    // event pulses
    input  wire sdim_pkg::sdim_events_t    events,
    // results
    output logic [11:0]                    dspSupplySample,
    output logic                           droopShutdown,
    output logic                           irqOut
);
    import sdim_pkg::*;

    // register state
    logic                    dspSupplySourceSelect;
    logic                    droopShutdownEnable;
    logic [7:0]              droopThresholdCode;
    logic [7:0]              systemIrqMask;
    logic [7:0]              outputHeadsetIrqMask;
    logic [7:0]              latchedSystemIrq;
    logic                    next_dspSupplySourceSelect;
    logic                    next_droopShutdownEnable;
    logic [7:0]              next_droopThresholdCode;
    logic [7:0]              next_systemIrqMask;
    logic [7:0]              next_outputHeadsetIrqMask;
    logic [7:0]              next_latchedSystemIrq;
    logic [7:0]              next_regRdata;
    logic                    next_regRvalid;
    // datapath state
    logic [11:0]             next_dspSupplySample;
    logic                    next_droopShutdown;
    logic                    next_irqOut;
    logic                    irqCause;
    logic [4:0]              ohEvents;
    logic [7:0]              avddUpper;

    assign ohEvents  = {events.outShort, events.drvVgnd, events.hsInsert, events.hsRemove, events.hsHook};
    assign avddUpper = avddSample[SDIM_SAMPLE_W-1:SDIM_THRESH_SHIFT];

    // register writes, latch updates and read data
    always_comb begin
        next_dspSupplySourceSelect = dspSupplySourceSelect;
        next_droopShutdownEnable   = droopShutdownEnable;
        next_droopThresholdCode    = droopThresholdCode;
        next_systemIrqMask         = systemIrqMask;
        next_outputHeadsetIrqMask  = outputHeadsetIrqMask;
        next_latchedSystemIrq      = latchedSystemIrq;
        next_regRdata              = regRdata;
        next_regRvalid             = regReq.read;
        if (regReq.write) begin
            case (regReq.addr)
                SDIM_ADDR_SUPPLY_CTRL: begin
                    next_dspSupplySourceSelect = regReq.wdata[SDIM_BIT_SUPPLY_SELECT];
                    next_droopShutdownEnable   = regReq.wdata[SDIM_BIT_DROOP_ENABLE];
                end
                SDIM_ADDR_DROOP_THRESH: next_droopThresholdCode   = regReq.wdata;
                SDIM_ADDR_SYS_MASK:     next_systemIrqMask        = regReq.wdata;
                SDIM_ADDR_OH_MASK:      next_outputHeadsetIrqMask = regReq.wdata;
                default: ;
            endcase
        end
        if (regReq.read) begin
            case (regReq.addr)
                SDIM_ADDR_SUPPLY_CTRL: next_regRdata = {6'h00, dspSupplySourceSelect, droopShutdownEnable};
                SDIM_ADDR_DROOP_THRESH: next_regRdata = droopThresholdCode;
                SDIM_ADDR_SYS_MASK:     next_regRdata = systemIrqMask;
                SDIM_ADDR_OH_MASK:      next_regRdata = outputHeadsetIrqMask;
                SDIM_ADDR_SYS_LATCH: begin
                    next_regRdata = latchedSystemIrq;
                    next_latchedSystemIrq = SDIM_RST_SYS_LATCH;
                end
                default:                next_regRdata = SDIM_READ_UNMAPPED;
            endcase
        end
        // a new event wins over the clear-on-read in the same cycle
        if (events.clkErr) begin
            next_latchedSystemIrq[SDIM_BIT_CLK_ERR] = 1'b1;
        end
        if (events.pllLock) begin
            next_latchedSystemIrq[SDIM_BIT_PLL_LOCK] = 1'b1;
        end
    end

    // register bank flops
    always_ff @(posedge clk) begin
        if (reset) begin
            dspSupplySourceSelect <= SDIM_RST_SUPPLY_CTRL[SDIM_BIT_SUPPLY_SELECT];
            droopShutdownEnable   <= SDIM_RST_SUPPLY_CTRL[SDIM_BIT_DROOP_ENABLE];
            droopThresholdCode    <= SDIM_RST_DROOP_THRESH;
            systemIrqMask         <= SDIM_RST_SYS_MASK;
            outputHeadsetIrqMask  <= SDIM_RST_OH_MASK;
            latchedSystemIrq      <= SDIM_RST_SYS_LATCH;
            regRdata              <= SDIM_READ_UNMAPPED;
            regRvalid             <= 1'b0;
        end else begin
            dspSupplySourceSelect <= next_dspSupplySourceSelect;
            droopShutdownEnable   <= next_droopShutdownEnable;
            droopThresholdCode    <= next_droopThresholdCode;
            systemIrqMask         <= next_systemIrqMask;
            outputHeadsetIrqMask  <= next_outputHeadsetIrqMask;
            latchedSystemIrq      <= next_latchedSystemIrq;
            regRdata              <= next_regRdata;
            regRvalid             <= next_regRvalid;
        end
    end

    // supply routing, droop detection and interrupt combine
    always_comb begin
        next_dspSupplySample = dspSupplySourceSelect ? avddSample : vbatSample;
        // threshold only governs shutdown when the analog supply is selected
        next_droopShutdown = droopShutdownEnable && dspSupplySourceSelect
                             && (avddUpper < droopThresholdCode);
        irqCause = (latchedSystemIrq[SDIM_BIT_CLK_ERR] && !systemIrqMask[SDIM_BIT_CLK_ERR])
                || (latchedSystemIrq[SDIM_BIT_PLL_LOCK] && !systemIrqMask[SDIM_BIT_PLL_LOCK])
                || (events.outShort && !outputHeadsetIrqMask[SDIM_BIT_OUT_SHORT])
                || (events.drvVgnd && !outputHeadsetIrqMask[SDIM_BIT_DRV_VGND])
                || (events.hsInsert && !outputHeadsetIrqMask[SDIM_BIT_HS_INSERT])
                || (events.hsRemove && !outputHeadsetIrqMask[SDIM_BIT_HS_REMOVE])
                || (events.hsHook && !outputHeadsetIrqMask[SDIM_BIT_HS_HOOK]);
        next_irqOut = irqCause;
    end

    // datapath flops
    always_ff @(posedge clk) begin
        if (reset) begin
            dspSupplySample <= 12'h000;
            droopShutdown   <= 1'b0;
            irqOut          <= 1'b0;
        end else begin
            dspSupplySample <= next_dspSupplySample;
            droopShutdown   <= next_droopShutdown;
            irqOut          <= next_irqOut;
        end
    end

    // checks on the routing, droop and interrupt behaviour
    property p_source_route;
        @(posedge clk) disable iff (reset)
        !$past(reset) |-> dspSupplySample == ($past(dspSupplySourceSelect) ? $past(avddSample) : $past(vbatSample));
    endproperty
    a_source_route: assert property (p_source_route) else $error("supply sample routed from wrong source");

    property p_droop_off;
        @(posedge clk) disable iff (reset)
        !droopShutdownEnable |=> !droopShutdown;
    endproperty
    a_droop_off: assert property (p_droop_off) else $error("shutdown asserted while disabled");

    property p_reset_values;
        @(posedge clk)
        reset |=> droopThresholdCode == 8'hbf && systemIrqMask == 8'hff && !droopShutdownEnable
                  && outputHeadsetIrqMask == 8'h00;
    endproperty
    a_reset_values: assert property (p_reset_values) else $error("wrong register reset value");

    property p_droop_cmp;
        @(posedge clk) disable iff (reset)
        droopShutdownEnable && dspSupplySourceSelect |=> droopShutdown == ($past(avddSample[11:4]) < $past(droopThresholdCode));
    endproperty
    a_droop_cmp: assert property (p_droop_cmp) else $error("droop compare against threshold wrong");

    property p_clk_err_irq;
        @(posedge clk) disable iff (reset)
        latchedSystemIrq[7] && !systemIrqMask[7] |=> irqOut;
    endproperty
    a_clk_err_irq: assert property (p_clk_err_irq) else $error("unmasked clock error gave no interrupt");

    property p_pll_irq;
        @(posedge clk) disable iff (reset)
        latchedSystemIrq[6] && !systemIrqMask[6] |=> irqOut;
    endproperty
    a_pll_irq: assert property (p_pll_irq) else $error("unmasked pll lock gave no interrupt");

    property p_oh_irq;
        @(posedge clk) disable iff (reset)
        (ohEvents & ~outputHeadsetIrqMask[5:1]) != 5'h00 |=> irqOut;
    endproperty
    a_oh_irq: assert property (p_oh_irq) else $error("unmasked output or headset event lost");

    property p_latch_clear;
        @(posedge clk) disable iff (reset)
        regReq.read && regReq.addr == 8'h34 && !events.clkErr && !events.pllLock |=> latchedSystemIrq == 8'h00;
    endproperty
    a_latch_clear: assert property (p_latch_clear) else $error("latched readback not cleared by read");

    property p_latch_set;
        @(posedge clk) disable iff (reset)
        events.clkErr |=> latchedSystemIrq[7];
    endproperty
    a_latch_set: assert property (p_latch_set) else $error("clock error event not latched");

    // cause rebuilt from masks and sources, so a masked event leaking through is caught
    property p_irq_cause;
        @(posedge clk) disable iff (reset)
        irqOut |-> $past(((latchedSystemIrq[7:6] & ~systemIrqMask[7:6]) != 2'h0)
                         || ((ohEvents & ~outputHeadsetIrqMask[5:1]) != 5'h00));
    endproperty
    a_irq_cause: assert property (p_irq_cause) else $error("interrupt without unmasked cause");

    property p_pll_latch_set;
        @(posedge clk) disable iff (reset)
        events.pllLock |=> latchedSystemIrq[SDIM_BIT_PLL_LOCK];
    endproperty
    a_pll_latch_set: assert property (p_pll_latch_set) else $error("pll lock event not latched");

    // latched bits only fall through a readback of the latch register
    property p_latch_hold;
        @(posedge clk) disable iff (reset)
        !(regReq.read && regReq.addr == SDIM_ADDR_SYS_LATCH)
            |=> (latchedSystemIrq & $past(latchedSystemIrq)) == $past(latchedSystemIrq);
    endproperty
    a_latch_hold: assert property (p_latch_hold) else $error("latched bit lost without readback");

    property p_latch_reserved;
        @(posedge clk) disable iff (reset)
        latchedSystemIrq[5:0] == 6'h00;
    endproperty
    a_latch_reserved: assert property (p_latch_reserved) else $error("reserved latch bits not zero");

    // register port checks: answer strobe, writes landing and read data
    property p_rvalid_pulse;
        @(posedge clk) disable iff (reset)
        !$past(reset) |-> regRvalid == $past(regReq.read);
    endproperty
    a_rvalid_pulse: assert property (p_rvalid_pulse) else $error("read answer strobe out of step");

    property p_ctrl_write;
        @(posedge clk) disable iff (reset)
        regReq.write && regReq.addr == SDIM_ADDR_SUPPLY_CTRL
            |=> dspSupplySourceSelect == $past(regReq.wdata[1])
                && droopShutdownEnable == $past(regReq.wdata[0]);
    endproperty
    a_ctrl_write: assert property (p_ctrl_write) else $error("supply control write not taken");

    property p_thresh_write;
        @(posedge clk) disable iff (reset)
        regReq.write && regReq.addr == SDIM_ADDR_DROOP_THRESH
            |=> droopThresholdCode == $past(regReq.wdata);
    endproperty
    a_thresh_write: assert property (p_thresh_write) else $error("threshold write not taken");

    property p_sys_mask_write;
        @(posedge clk) disable iff (reset)
        regReq.write && regReq.addr == SDIM_ADDR_SYS_MASK
            |=> systemIrqMask == $past(regReq.wdata);
    endproperty
    a_sys_mask_write: assert property (p_sys_mask_write) else $error("system mask write not taken");

    property p_oh_mask_write;
        @(posedge clk) disable iff (reset)
        regReq.write && regReq.addr == SDIM_ADDR_OH_MASK
            |=> outputHeadsetIrqMask == $past(regReq.wdata);
    endproperty
    a_oh_mask_write: assert property (p_oh_mask_write) else $error("output headset mask write not taken");

    property p_ctrl_readback;
        @(posedge clk) disable iff (reset)
        regReq.read && regReq.addr == SDIM_ADDR_SUPPLY_CTRL
            |=> regRdata == {6'h00, $past(dspSupplySourceSelect), $past(droopShutdownEnable)};
    endproperty
    a_ctrl_readback: assert property (p_ctrl_readback) else $error("supply control read wrong");

    property p_thresh_readback;
        @(posedge clk) disable iff (reset)
        regReq.read && regReq.addr == SDIM_ADDR_DROOP_THRESH
            |=> regRdata == $past(droopThresholdCode);
    endproperty
    a_thresh_readback: assert property (p_thresh_readback) else $error("threshold read wrong");

    property p_sys_mask_readback;
        @(posedge clk) disable iff (reset)
        regReq.read && regReq.addr == SDIM_ADDR_SYS_MASK
            |=> regRdata == $past(systemIrqMask);
    endproperty
    a_sys_mask_readback: assert property (p_sys_mask_readback) else $error("system mask read wrong");

    property p_oh_mask_readback;
        @(posedge clk) disable iff (reset)
        regReq.read && regReq.addr == SDIM_ADDR_OH_MASK
            |=> regRdata == $past(outputHeadsetIrqMask);
    endproperty
    a_oh_mask_readback: assert property (p_oh_mask_readback) else $error("output headset mask read wrong");

    // with the battery measurement selected the threshold never trips shutdown
    property p_vbat_no_droop;
        @(posedge clk) disable iff (reset)
        !dspSupplySourceSelect |=> !droopShutdown;
    endproperty
    a_vbat_no_droop: assert property (p_vbat_no_droop) else $error("shutdown with battery source selected");

    // main scenarios
    c_droop_trip:  cover property (@(posedge clk) disable iff (reset) $rose(droopShutdown));
    c_irq_fire:    cover property (@(posedge clk) disable iff (reset) $rose(irqOut));
    c_read_clear:  cover property (@(posedge clk) disable iff (reset)
                                   latchedSystemIrq[7] && regReq.read && regReq.addr == 8'h34);
    c_avdd_select: cover property (@(posedge clk) disable iff (reset) $rose(dspSupplySourceSelect));
    c_masked_latch: cover property (@(posedge clk) disable iff (reset) latchedSystemIrq[7] && systemIrqMask[7]);
endmodule

// >>> verif/sdim_src.sv
// sdim_src: stand-in for the converter and event logic that feeds the register bank
// assumes the bench drives its requests on clk by non-blocking assignment
`timescale 1ns/10ps
module sdim_src (
    // clock and reset
    input  wire logic                   clk,
    input  wire logic                   reset,
    // requests from the bench
    input  wire sdim_pkg::sdim_events_t pulseReq,
    input  wire logic [11:0]            vbatIn,
    input  wire logic [11:0]            avddIn,
    // towards the register bank
    output sdim_pkg::sdim_events_t      events,
    output logic [11:0]                 vbatSample,
    output logic [11:0]                 avddSample
);
    import sdim_pkg::*;
    // registered so each event is a clean one-cycle pulse and samples change only on clk
    always_ff @(posedge clk) begin
        if (reset) begin
            events     <= '0;
            vbatSample <= 12'h000;
            avddSample <= 12'h000;
        end else begin
            events     <= pulseReq;
            vbatSample <= vbatIn;
            avddSample <= avddIn;
        end
    end
endmodule

// >>> verif/test_supply_droop_and_irq_mask_regs.sv
// test_supply_droop_and_irq_mask_regs: self-checking bench for the register bank
// assumes one 200 MHz clock, synchronous active-high reset, one-cycle access strobes
`timescale 1ns/10ps
module test_supply_droop_and_irq_mask_regs;
    import sdim_pkg::*;
    logic         clk, reset, regRvalid, droopShutdown, irqOut, a, b;
    sdim_req_t    regReq;
    sdim_events_t pulseReq, events;
    logic [11:0]  vbatIn, avddIn, vbatSample, avddSample, dspSupplySample;
    logic [7:0]   regRdata;
    int           failures, cmp_count;

    // design and its event and converter source
    sdim_regs dut (.clk(clk), .reset(reset), .regReq(regReq), .regRdata(regRdata), .regRvalid(regRvalid),
        .vbatSample(vbatSample), .avddSample(avddSample), .events(events),
        .dspSupplySample(dspSupplySample), .droopShutdown(droopShutdown), .irqOut(irqOut));
    sdim_src farSide (.clk(clk), .reset(reset), .pulseReq(pulseReq), .vbatIn(vbatIn), .avddIn(avddIn),
        .events(events), .vbatSample(vbatSample), .avddSample(avddSample));

    // compare one value, count it, report a difference
    task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // one write strobe, held for exactly one cycle
    task automatic wr(input logic [7:0] adr, input logic [7:0] d);
        @(posedge clk);
        regReq <= '{write: 1'b1, read: 1'b0, addr: adr, wdata: d};
        @(posedge clk);
        regReq.write <= 1'b0;
    endtask

    // one read strobe; answer is looked at in the cycle after it is taken
    task automatic rdchk(input logic [7:0] adr, input logic [7:0] exp);
        @(posedge clk);
        regReq <= '{write: 1'b0, read: 1'b1, addr: adr, wdata: 8'h00};
        @(posedge clk);
        regReq.read <= 1'b0;
        #1;
        check("regRvalid", regRvalid, 1'b1);
        check($sformatf("regRdata at %h", adr), regRdata, exp);
    endtask

    // one event pulse; irq sampled two and three edges after the request
    task automatic pulse(input sdim_events_t ev, output logic i2, output logic i3);
        @(posedge clk);
        pulseReq <= ev;
        @(posedge clk);
        pulseReq <= '0;
        @(posedge clk);
        #1 i2 = irqOut;
        @(posedge clk);
        #1 i3 = irqOut;
    endtask

    // apply supply samples and look at the selected value and shutdown flag once settled
    task automatic supply(input logic [11:0] v, input logic [11:0] av, input logic [11:0] expS, input logic expD);
        @(posedge clk);
        vbatIn <= v;
        avddIn <= av;
        repeat (3) @(posedge clk);
        #1;
        check("dspSupplySample", dspSupplySample, expS);
        check("droopShutdown", droopShutdown, {11'h000, expD});
    endtask

    // report counts and verdict, then stop
    task automatic conclude;
        $display("checks %0d failures %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // clock
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // watchdog against a hang
    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        $display("mismatch watchdog expected done seen timeout");
        conclude();
    end

    // main sequence
    initial begin
        reset = 1'b1;
        regReq = '0;
        pulseReq = '0;
        vbatIn = 12'h000;
        avddIn = 12'h000;
        failures = 0;
        cmp_count = 0;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        // reset values and an unmapped place
        rdchk(SDIM_ADDR_SUPPLY_CTRL, 8'h00);
        rdchk(SDIM_ADDR_DROOP_THRESH, 8'hbf);
        rdchk(SDIM_ADDR_SYS_MASK, 8'hff);
        rdchk(SDIM_ADDR_OH_MASK, 8'h00);
        rdchk(SDIM_ADDR_SYS_LATCH, 8'h00);
        rdchk(8'h40, 8'h00);
        // source select and droop compare, including the threshold boundary
        supply(12'h123, 12'h4f0, 12'h123, 1'b0);
        wr(SDIM_ADDR_SUPPLY_CTRL, 8'h02);
        supply(12'h123, 12'h4f0, 12'h4f0, 1'b0);
        wr(SDIM_ADDR_DROOP_THRESH, 8'h50);
        rdchk(SDIM_ADDR_DROOP_THRESH, 8'h50);
        wr(SDIM_ADDR_SUPPLY_CTRL, 8'h03);
        supply(12'h123, 12'h4ff, 12'h4ff, 1'b1);
        supply(12'h123, 12'h500, 12'h500, 1'b0);
        wr(SDIM_ADDR_SUPPLY_CTRL, 8'hfd);
        supply(12'h123, 12'h4f0, 12'h123, 1'b0);
        rdchk(SDIM_ADDR_SUPPLY_CTRL, 8'h01);
        // system events unmasked: latched, irq three edges after the request, cleared by readback
        wr(SDIM_ADDR_SYS_MASK, 8'h3f);
        pulse(sdim_events_t'(7'h40), a, b);
        check("irq clock error", {a, b}, 2'b01);
        rdchk(SDIM_ADDR_SYS_LATCH, 8'h80);
        repeat (2) @(posedge clk);
        #1 check("irq after readback", irqOut, 1'b0);
        pulse(sdim_events_t'(7'h20), a, b);
        check("irq pll lock", {a, b}, 2'b01);
        rdchk(SDIM_ADDR_SYS_LATCH, 8'h40);
        // system events masked: still latched, no irq; latch ignores writes
        wr(SDIM_ADDR_SYS_MASK, 8'hff);
        pulse(sdim_events_t'(7'h40), a, b);
        check("irq clock error masked", {a, b}, 2'b00);
        pulse(sdim_events_t'(7'h20), a, b);
        check("irq pll lock masked", {a, b}, 2'b00);
        wr(SDIM_ADDR_SYS_LATCH, 8'h00);
        rdchk(SDIM_ADDR_SYS_LATCH, 8'hc0);
        rdchk(SDIM_ADDR_SYS_LATCH, 8'h00);
        // output and headset events, each unmasked then masked
        for (int i = 1; i <= 5; i++) begin
            wr(SDIM_ADDR_OH_MASK, 8'h3e & ~(8'h01 << i));
            pulse(sdim_events_t'(7'h01 << (i - 1)), a, b);
            check($sformatf("irq unmasked bit %0d", i), {a, b}, 2'b10);
            wr(SDIM_ADDR_OH_MASK, 8'h01 << i);
            pulse(sdim_events_t'(7'h01 << (i - 1)), a, b);
            check($sformatf("irq masked bit %0d", i), {a, b}, 2'b00);
        end
        rdchk(SDIM_ADDR_OH_MASK, 8'h20);
        conclude();
    end
endmodule
